// *** src/vbisc_pkg.sv ***
// Package for the slicer control register bank.
// Assumes the host reaches registers through a simple byte-wide register
// port decoded behind the I2C slave, in the clk domain.
package vbisc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_SOFT_ERR   = 8'hB3; // Soft error count, clear on read
  localparam logic [7:0] ADDR_COEFF_RD   = 8'hB6; // Filter coefficient readback
  localparam logic [7:0] ADDR_LEVEL_RD   = 8'hB7; // Slicer level readback
  localparam logic [7:0] ADDR_ACCU_CTRL  = 8'hC7; // Accumulator control
  localparam logic [7:0] ADDR_STD_SEL    = 8'hC9; // Service standard select

  // Accumulator control field positions
  localparam int ACC_RESET_BIT = 0; // One-shot accumulator clear
  localparam int ACC_DCDIS_BIT = 1; // DC accumulator disable
  localparam int ACC_ACDIS_BIT = 2; // AC and filter accumulator disable
  localparam int ACC_SOFTD_BIT = 3; // Soft correction disable
  localparam int ACC_ACAD_BIT  = 4; // AC adaption enable
  localparam int ACC_FLTAD_BIT = 5; // Filter adaption enable

  // Standard select field positions
  localparam int STD_TTX_BIT    = 0; // Teletext slicing
  localparam int STD_NTSC_BIT   = 1; // NTSC line timing
  localparam int STD_FULL_BIT   = 2; // Full-field operation
  localparam int STD_VPS_BIT    = 3; // VPS on line 16
  localparam int STD_WSS_BIT    = 4; // WSS on line 23
  localparam int STD_CC1_BIT    = 5; // Caption line 21 field 1
  localparam int STD_CC2_BIT    = 6; // Caption line 21 field 2
  localparam int STD_NOQUIT_BIT = 7; // Horizontal quit suppressed

  // Coefficient readback widening
  localparam int COEFF_SIGN_BIT = 5; // Sign of the six-bit coefficient
  localparam int COEFF_PAD      = 2; // Copies of the sign above it

  // Reset values (bit 0 is a command and never stored)
  localparam logic [7:0] ACC_CTRL_RST = 8'h34; // Adaption on, DC on, AC and filter off
  localparam logic [7:0] STD_SEL_RST  = 8'h0D; // Teletext, full field, VPS
  localparam logic [7:0] ACC_WR_MASK  = 8'h3E; // Stored bits of accumulator control
  localparam logic [7:0] CNT_MAX      = 8'hFF; // Saturation value of soft count
  localparam logic [7:0] CNT_ONE      = 8'h01; // Counter increment
  localparam logic [7:0] ZERO8        = 8'h00; // Cleared byte

  // Steering signals to the slicer core
  typedef struct packed {
    logic accClear;      // One-cycle pulse, clear DC, AC and filter accumulators
    logic dcRun;         // DC accumulator running
    logic acFltRun;      // AC and filter accumulators running (gated by line type)
    logic softCorrEn;    // Soft error correction active
    logic acAdaptEn;     // AC adaptive loop active
    logic fltAdaptEn;    // Filter adaptive loop active
  } vbisc_accu_t;

  typedef struct packed {
    logic ttxEnable;           // Teletext slicing
    logic ntscMode;            // 1 NTSC line timing, 0 PAL
    logic fullField;           // Full-field operation
    logic vpsEnable;           // VPS on line 16
    logic wssEnable;           // WSS on line 23
    logic cc_first_field_enable;  // Caption line 21 field 1
    logic cc_second_field_enable; // Caption line 21 field 2
    logic hQuitEnable;         // Horizontal quit generated
  } vbisc_std_t;

endpackage : vbisc_pkg

// *** src/vbisc_regs.sv ***
// Control and status register bank of the data slicer.
// Assumes a byte register port in the clk domain behind the I2C slave:
// regWr and regRd are one-cycle strobes, read data is valid the next cycle.
// Slicer core supplies coefficient, level, line type and correction events.
// Steering outputs follow a write by two edges, since they are registered; the accClear pulse follows by one edge.
// Control registers have no read path; the host must keep its own copy.

module vbisc_regs
  import vbisc_pkg::*;
(
  input  wire logic       clk,          // 100 MHz system clock
  input  wire logic       rst,          // Async reset, active high
  input  wire logic [7:0] regAddr,      // Register address
  input  wire logic [7:0] regWdata,     // Write data
  input  wire logic       regWr,        // Write strobe
  input  wire logic       regRd,        // Read strobe
  output logic      [7:0] regRdata,     // Read data, one cycle after strobe
  input  wire logic [5:0] coeffCur,     // Adapted filter coefficient
  input  wire logic [7:0] levelCur,     // Slicer level in effect
  input  wire logic       lineAcFlt,    // Current line is VPS, caption or WSS
  input  wire logic       softFixEvt,   // One byte repaired by soft correction
  output vbisc_accu_t     accuCtl,      // Accumulator steering
  output vbisc_std_t      stdCtl        // Service selection
);

  logic [7:0] accuReg;   // Stored accumulator control bits
  logic [7:0] stdReg;    // Stored standard select
  logic [7:0] softCount; // Soft error count

  // Exact byte compare; a partial decode would alias the sparse map
  function automatic logic addrIs(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction : addrIs

  // Six-bit coefficient widened to the byte bus, sign kept
  function automatic logic [7:0] signExtCoeff(input logic [5:0] coeff);
    return {{COEFF_PAD{coeff[COEFF_SIGN_BIT]}}, coeff};
  endfunction : signExtCoeff

  // Written bits merged with fixed ones; command and reserved bits never stick
  function automatic logic [7:0] accuStore(input logic [7:0] wdata);
    return (wdata & ACC_WR_MASK) | (ACC_CTRL_RST & ~ACC_WR_MASK);
  endfunction : accuStore

  // Address decode
  wire hitAccu  = addrIs(regAddr, ADDR_ACCU_CTRL);
  wire hitStd   = addrIs(regAddr, ADDR_STD_SEL);
  wire hitSoft  = addrIs(regAddr, ADDR_SOFT_ERR);
  wire hitCoeff = addrIs(regAddr, ADDR_COEFF_RD);
  wire hitLevel = addrIs(regAddr, ADDR_LEVEL_RD);
  // Write and read qualifiers
  wire wrAccu   = regWr && hitAccu;
  wire wrStd    = regWr && hitStd;
  wire rdSoft   = regRd && hitSoft;
  // Clear command taken from data bit, never stored, so writing zero is a no-op
  wire clrCmd   = wrAccu && regWdata[ACC_RESET_BIT];

  // Read mux; write-only registers read as zero
  wire [7:0] rdMux = hitSoft  ? softCount :
                     hitCoeff ? signExtCoeff(coeffCur) :
                     hitLevel ? levelCur :
                     ZERO8;

  // Steering decode
  // Line type gates every AC and filter control, adaption included
  wire [7:0] next_accu = accuStore(regWdata); // Only bits 5:1 survive a write
  vbisc_accu_t next_accuCtl;
  vbisc_std_t  next_stdCtl;
  assign next_accuCtl.accClear   = clrCmd;
  assign next_accuCtl.dcRun      = !accuReg[ACC_DCDIS_BIT];
  assign next_accuCtl.acFltRun   = !accuReg[ACC_ACDIS_BIT] && lineAcFlt;
  assign next_accuCtl.softCorrEn = !accuReg[ACC_SOFTD_BIT];
  assign next_accuCtl.acAdaptEn  = accuReg[ACC_ACAD_BIT] && lineAcFlt;
  assign next_accuCtl.fltAdaptEn = accuReg[ACC_FLTAD_BIT] && lineAcFlt;
  // Standard bits pass straight through, quit enable inverted
  assign next_stdCtl.ttxEnable   = stdReg[STD_TTX_BIT];
  assign next_stdCtl.ntscMode    = stdReg[STD_NTSC_BIT];
  assign next_stdCtl.fullField   = stdReg[STD_FULL_BIT];
  assign next_stdCtl.vpsEnable   = stdReg[STD_VPS_BIT];
  assign next_stdCtl.wssEnable   = stdReg[STD_WSS_BIT];
  assign next_stdCtl.cc_first_field_enable  = stdReg[STD_CC1_BIT];
  assign next_stdCtl.cc_second_field_enable = stdReg[STD_CC2_BIT];
  assign next_stdCtl.hQuitEnable = !stdReg[STD_NOQUIT_BIT];

  // Stored control registers
  // Bit 0 of the accumulator byte is a command, masked before storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accuReg <= ACC_CTRL_RST;
      stdReg  <= STD_SEL_RST;
    end else begin
      if (wrAccu) accuReg <= next_accu;
      if (wrStd)  stdReg  <= regWdata;
    end
  end

  // Registered outputs
  // Read data falls back to zero between reads, so a stale byte never looks fresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= ZERO8;
      accuCtl  <= '0;
      stdCtl   <= '0;
    end else begin
      regRdata <= regRd ? rdMux : ZERO8;
      accuCtl  <= next_accuCtl;
      stdCtl   <= next_stdCtl;
    end
  end

  // Soft error counter; only counts while correction is enabled
  // Events that arrive while correction is off are dropped, not held over
  vbisc_soft_counter u_softCnt (
    .clk      (clk),
    .rst      (rst),
    .countEvt (softFixEvt && accuCtl.softCorrEn),
    .readClr  (rdSoft),
    .count    (softCount)
  );

  // Command path: a write of one gives exactly one clear pulse
  sequence s_clearWrite;
    wrAccu && regWdata[ACC_RESET_BIT];
  endsequence
  sequence s_onePulse;
    accuCtl.accClear ##1 !accuCtl.accClear;
  endsequence
  // Standard write, whose effect reaches the outputs two edges on
  sequence s_stdWrite;
    wrStd ##1 1'b1;
  endsequence

  AST_CLEAR_ONESHOT: assert property (@(posedge clk) disable iff (rst)
    s_clearWrite |=> s_onePulse)
    else $error("accumulator clear not a single pulse");
  AST_NO_CLEAR_ON_ZERO: assert property (@(posedge clk) disable iff (rst)
    !(wrAccu && regWdata[ACC_RESET_BIT]) |=> !accuCtl.accClear)
    else $error("accumulator clear without command");
  AST_DC_RUN: assert property (@(posedge clk) disable iff (rst)
    wrAccu ##1 1'b1 |=> accuCtl.dcRun == !$past(regWdata[ACC_DCDIS_BIT], 2))
    else $error("DC run does not follow disable bit");
  AST_ACFLT_LINE: assert property (@(posedge clk) disable iff (rst)
    !lineAcFlt |=> !accuCtl.acFltRun && !accuCtl.acAdaptEn && !accuCtl.fltAdaptEn)
    else $error("AC or filter loop active on other line");
  AST_SOFT_CORR: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> accuCtl.softCorrEn == !$past(accuReg[ACC_SOFTD_BIT]))
    else $error("soft correction enable wrong");
  AST_COEFF_READ: assert property (@(posedge clk) disable iff (rst)
    (regRd && hitCoeff) |=> regRdata == signExtCoeff($past(coeffCur)))
    else $error("coefficient readback wrong");
  AST_LEVEL_READ: assert property (@(posedge clk) disable iff (rst)
    (regRd && hitLevel) |=> regRdata == $past(levelCur))
    else $error("level readback wrong");
  AST_CC_FIELDS: assert property (@(posedge clk) disable iff (rst)
    wrStd ##1 1'b1 |=> stdCtl.cc_second_field_enable == $past(regWdata[STD_CC2_BIT], 2)
                       && stdCtl.cc_first_field_enable == $past(regWdata[STD_CC1_BIT], 2))
    else $error("caption field enables wrong");
  AST_HQUIT: assert property (@(posedge clk) disable iff (rst)
    wrStd ##1 1'b1 |=> stdCtl.hQuitEnable == !$past(regWdata[STD_NOQUIT_BIT], 2))
    else $error("horizontal quit polarity wrong");

  // Host writes are spaced, so a two-edge lookback sees one write only;
  // stored bits change only on a write, and bit 0 is never kept
  AST_ACCU_STORE: assert property (@(posedge clk) disable iff (rst)
    wrAccu |=> accuReg == accuStore($past(regWdata)) && !accuReg[ACC_RESET_BIT])
    else $error("accumulator control stored wrong");
  AST_ACCU_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wrAccu |=> $stable(accuReg))
    else $error("accumulator control changed without write");
  AST_STD_HOLD: assert property (@(posedge clk) disable iff (rst)
    !wrStd |=> $stable(stdReg))
    else $error("standard select changed without write");

  // Steady steering; the first edge after reset release still shows zeros
  AST_AC_RUN: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> accuCtl.acFltRun == (!$past(accuReg[ACC_ACDIS_BIT]) && $past(lineAcFlt)))
    else $error("AC and filter run wrong");
  AST_ADAPT: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> accuCtl.acAdaptEn == ($past(accuReg[ACC_ACAD_BIT]) && $past(lineAcFlt))
                    && accuCtl.fltAdaptEn == ($past(accuReg[ACC_FLTAD_BIT]) && $past(lineAcFlt)))
    else $error("adaption enables wrong");
  AST_SOFT_GATED: assert property (@(posedge clk) disable iff (rst)
    (softFixEvt && !accuCtl.softCorrEn && !rdSoft) |=> softCount == $past(softCount))
    else $error("soft count moved while correction off");
  AST_HQUIT_STEADY: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> stdCtl.hQuitEnable == !$past(stdReg[STD_NOQUIT_BIT]))
    else $error("horizontal quit does not follow stored bit");

  // Read path; the byte is taken from the soft counter or the core at the strobe edge
  AST_SOFT_READ: assert property (@(posedge clk) disable iff (rst)
    rdSoft |=> regRdata == $past(softCount))
    else $error("soft count readback wrong");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> regRdata == ZERO8)
    else $error("read data not zero between reads");
  // Writes to readback places must leave every control untouched
  AST_NO_WRITE_RO: assert property (@(posedge clk) disable iff (rst)
    (regWr && (hitSoft || hitCoeff || hitLevel)) |=> $stable(accuReg) && $stable(stdReg))
    else $error("write to read-only place changed a control");

  // Each service bit follows its own written bit
  AST_STD_BITS: assert property (@(posedge clk) disable iff (rst)
    s_stdWrite |=> stdCtl.ttxEnable == $past(regWdata[STD_TTX_BIT], 2)
                   && stdCtl.ntscMode == $past(regWdata[STD_NTSC_BIT], 2)
                   && stdCtl.fullField == $past(regWdata[STD_FULL_BIT], 2)
                   && stdCtl.vpsEnable == $past(regWdata[STD_VPS_BIT], 2)
                   && stdCtl.wssEnable == $past(regWdata[STD_WSS_BIT], 2))
    else $error("standard service bits wrong");

endmodule : vbisc_regs

// *** src/vbisc_soft_counter.sv ***
// Saturating soft error counter with clear on read.
// Assumes corrected-byte events are one-cycle pulses in the clk domain.
module vbisc_soft_counter
  import vbisc_pkg::*;
(
  input  wire logic       clk,       // System clock
  input  wire logic       rst,       // Async reset, active high
  input  wire logic       countEvt,  // One corrected byte
  input  wire logic       readClr,   // Host read of the counter
  output logic [7:0]      count      // Current count
);

  logic [7:0] next_count; // Next count value
  wire        atMax = (count == CNT_MAX); // Saturated

  // Event during a read cycle starts the new count at one, so it is not lost
  always_comb begin
    if (readClr) begin
      next_count = countEvt ? CNT_ONE : ZERO8;
    end else if (countEvt && !atMax) begin
      next_count = count + CNT_ONE;
    end else begin
      next_count = count; // Hold, including at 255
    end
  end

  // Counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= ZERO8;
    end else begin
      count <= next_count;
    end
  end

  AST_SATURATE: assert property (@(posedge clk) disable iff (rst)
    (count == CNT_MAX && !readClr) |=> count == CNT_MAX)
    else $error("soft count left saturation without read");
  AST_CLEAR_ON_READ: assert property (@(posedge clk) disable iff (rst)
    readClr |=> count <= CNT_ONE)
    else $error("soft count not cleared after read");
  AST_COUNT_UP: assert property (@(posedge clk) disable iff (rst)
    (countEvt && !readClr && count != CNT_MAX) |=> count == $past(count) + CNT_ONE)
    else $error("soft count missed an increment");

endmodule : vbisc_soft_counter

// *** verification/test_vbisc_regs.sv ***
// Self-checking bench for the slicer control register bank.
// Assumes the host model owns the register port; core inputs are driven here.
module test_vbisc_regs
  import vbisc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, regWr, regRd, lineAcFlt, softFixEvt; // Clock, reset, strobes
  logic [7:0]  regAddr, regWdata, regRdata, levelCur, v, d;  // Port bytes, scratch
  logic [5:0]  coeffCur;                  // Coefficient from core
  vbisc_accu_t accuCtl;                   // Accumulator steering
  vbisc_std_t  stdCtl;                    // Service selection
  logic [31:0] seed;                      // Xorshift state
  logic [7:0]  accM;                      // Model of stored accumulator bits
  int          mCnt, miscompares, total_checks; // Model count and tallies
  logic [7:0]  woAddr [3] = '{ADDR_ACCU_CTRL, ADDR_STD_SEL, 8'hA0}; // Write-only and unmapped places

  vbisc_regs i_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .coeffCur(coeffCur), .levelCur(levelCur),
    .lineAcFlt(lineAcFlt), .softFixEvt(softFixEvt), .accuCtl(accuCtl), .stdCtl(stdCtl));
  vbisc_host_model i_host (.clk(clk), .regRdata(regRdata), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Xorshift source, fixed start
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Single comparison point
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Back-to-back correction events; model saturates, gated by soft enable
  task automatic softRun(input int n);
    repeat (n) @(posedge clk) softFixEvt <= 1'b1;
    @(posedge clk) softFixEvt <= 1'b0;
    if (!accM[3]) mCnt = (mCnt + n > 255) ? 255 : mCnt + n;
  endtask : softRun

  // Counter read, model clears after the read
  task automatic rdCnt();
    i_host.rd(ADDR_SOFT_ERR, d);
    chk("softCount", d, 8'(mCnt));
    mCnt = 0;
  endtask : rdCnt

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well past the longest sequence
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    {clk, rst, lineAcFlt, softFixEvt, coeffCur, levelCur} = 18'h18000;
    {seed, accM, mCnt, miscompares, total_checks} = {32'd22409, 8'h34, 96'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("accuCtlDefault", 8'(accuCtl), 8'h17);
    chk("stdCtlDefault", 8'(stdCtl), 8'hB1);
    @(posedge clk) lineAcFlt <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("accuCtlOtherLine", 8'(accuCtl), 8'h14);
    // Write-only and unmapped places read as zero
    foreach (woAddr[k]) begin
      i_host.rd(woAddr[k], d);
      chk("woRead", d, 8'h00);
    end
    // Every standard bit alone, then random patterns
    for (int i = 0; i < 14; i++) begin
      v = (i < 8) ? 8'(1 << i) : rnd();
      i_host.wr(ADDR_STD_SEL, v);
      @(posedge clk);
      #1 chk("stdCtl", 8'(stdCtl), {v[0], v[1], v[2], v[3], v[4], v[5], v[6], ~v[7]});
    end
    // Accumulator control with line type varying
    for (int i = 0; i < 16; i++) begin
      v = (i == 0) ? 8'h01 : rnd();
      @(posedge clk) lineAcFlt <= v[7];
      i_host.wr(ADDR_ACCU_CTRL, v);
      #1 chk("accClearPulse", 8'(accuCtl.accClear), 8'(v[0]));
      @(posedge clk);
      #1 chk("accuCtl", 8'(accuCtl), {3'b000, ~v[1], ~v[2] & v[7], ~v[3], v[4] & v[7], v[5] & v[7]});
    end
    i_host.wr(ADDR_ACCU_CTRL, 8'h30);
    // Readbacks follow the core, writes to the coefficient place ignored
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      @(posedge clk) {coeffCur, levelCur} <= {v[5:0], ~v};
      i_host.wr(ADDR_COEFF_RD, rnd());
      i_host.rd(ADDR_COEFF_RD, d);
      chk("coeffRead", d, {{2{v[5]}}, v[5:0]});
      i_host.rd(ADDR_LEVEL_RD, d);
      chk("levelRead", d, ~v);
    end
    // Count, clear on read, saturation, then correction off
    rdCnt();
    softRun(5);
    rdCnt();
    rdCnt();
    softRun(300);
    rdCnt();
    i_host.wr(ADDR_ACCU_CTRL, 8'h38);
    accM = 8'h38;
    softRun(3);
    rdCnt();
    complete_run();
  end
endmodule : test_vbisc_regs

// *** verification/vbisc_host_model.sv ***
// Host side of the register port, standing in for the I2C bridge.
// Assumes one-cycle strobes and read data one cycle after the read strobe.
module vbisc_host_model (
  input  wire logic       clk,      // System clock
  input  wire logic [7:0] regRdata, // Read data from the bank
  output logic      [7:0] regAddr,  // Register address
  output logic      [7:0] regWdata, // Write data
  output logic            regWr,    // Write strobe
  output logic            regRd     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial {regAddr, regWdata, regWr, regRd} = 18'h00000;

  // One write strobe; released lines flip so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= dat;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~dat;
  endtask : wr

  // One read strobe; data taken while it stands in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
    #1 dat = regRdata;
  endtask : rd
endmodule : vbisc_host_model
